//--- design/pwr_wake_ctrl.sv
// Power-down wake, power-on reset timing and boot strap sampling
// ----------------------------------------
// ----------------------------------------
`timescale 1ns/1ns
`default_nettype none
module pwr_wake_ctrl
  import pwr_wake_pkg::*;
#(
  parameter int unsigned POR_CYCLES = POR_DELAY_CYC
) (
  // Clock and reset
  input  wire logic           clk,
  input  wire logic           rst_b,
  // Supply comparators, asynchronous
  input  wire logic           supply_above_rise,
  input  wire logic           supply_above_fall,
  // Manual reset pin, active low, asynchronous
  input  wire logic           reset_pin_b,
  // Program strobe strap pin
  input  wire logic           strap_in,
  output logic                strap_out,
  output logic                strap_oe,
  input  wire logic           strobe_drive,
  // Core side
  input  wire logic           pd_request,
  input  wire power_control_t power_control_reg,
  input  wire logic           interval_counter_irq,
  input  wire logic           serial_irq,
  input  wire logic           ext_irq_line_b,
  input  wire logic           interrupt_return,
  // Outputs to core and clocking
  output logic                core_reset,
  output logic                download_mode,
  output logic                pll_run,
  output logic                core_clk_en,
  output logic                ic_clk_en,
  output wake_src_t           wake_irq,
  output logic                resume_next
);

  // Zero would leave the release timer done straight out of reset
  if (POR_CYCLES < 1) begin : g_bad_por_cycles
    $error("POR_CYCLES must be at least one");
  end

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [3:0] s1_reg;
  logic [3:0] s2_reg;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_reg <= 4'h0;
      s2_reg <= 4'h0;
    end else begin
      s1_reg <= {supply_above_rise, supply_above_fall, reset_pin_b, strap_in};
      s2_reg <= s1_reg;
    end
  end
  wire rise_ok   = s2_reg[3];
  wire fall_ok   = s2_reg[2];
  wire pin_rst   = ~s2_reg[1];
  wire strap_lvl = s2_reg[0];

  // ----------------------------------------
  // Power-on reset supply qualification
  // ----------------------------------------
  // Reset holds below the high threshold whichever way the supply moves,
  // so the core never runs in the band down to the low threshold
  logic supply_good_reg;
  wire  supply_good_next = rise_ok & fall_ok;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) supply_good_reg <= 1'b0;
    else        supply_good_reg <= supply_good_next;
  end

  // ----------------------------------------
  // Release delay timer
  // ----------------------------------------
  localparam int unsigned CW = $clog2(POR_CYCLES + 1);
  logic [CW-1:0] por_cnt_reg;
  wire           por_done = (por_cnt_reg == CW'(POR_CYCLES));
  wire           hold_rst = ~supply_good_reg | pin_rst;
  // count 128 ms after supply good
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)        por_cnt_reg <= '0;
    else if (hold_rst) por_cnt_reg <= '0;
    else if (!por_done) por_cnt_reg <= por_cnt_reg + CW'(1);
  end

  // ----------------------------------------
  // Power state machine
  // ----------------------------------------
  pwr_state_t state_reg;
  pwr_state_t state_next;
  wake_src_t  wake_hit;
  wake_src_t  wake_hit_reg;

  wire   wake_timer  = interval_counter_irq;
  wire   wake_serial = serial_irq & power_control_reg.serial_wake_enable;
  wire   wake_ext    = ~ext_irq_line_b & power_control_reg.ext_irq_wake_enable;
  // One driver for the whole struct
  assign wake_hit    = {wake_timer, wake_serial, wake_ext};
  wire any_wake = |wake_hit;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_RESET: if (por_done) state_next = ST_RUN;
      ST_RUN:   if (pd_request) state_next = ST_PDOWN;
      ST_PDOWN: if (any_wake) state_next = ST_WAKE;
      ST_WAKE:  if (interrupt_return) state_next = ST_RUN;
      default:  state_next = ST_RESET;
    endcase
    if (hold_rst) state_next = ST_RESET;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) state_reg <= ST_RESET;
    else        state_reg <= state_next;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)                             wake_hit_reg <= '0;
    else if (state_reg == ST_PDOWN && any_wake) wake_hit_reg <= wake_hit;
    else if (state_next != ST_WAKE)         wake_hit_reg <= '0;
  end

  // ----------------------------------------
  // Strap sampling at reset release
  // ----------------------------------------
  // sample strap only at release
  wire release_now = (state_reg == ST_RESET) && (state_next == ST_RUN);
  logic dl_reg;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)           dl_reg <= 1'b0;
    else if (release_now) dl_reg <= ~strap_lvl;
    else if (hold_rst)    dl_reg <= 1'b0;
  end

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  wire running = (state_next == ST_RUN) || (state_next == ST_WAKE);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      core_reset  <= 1'b1;
      pll_run     <= 1'b0;
      core_clk_en <= 1'b0;
      ic_clk_en   <= 1'b0;
      strap_oe    <= 1'b0;
      strap_out   <= 1'b1;
      wake_irq    <= '0;
      resume_next <= 1'b0;
    end else begin
      core_reset  <= (state_next == ST_RESET);
      // clocks stop in power-down, interval counter keeps clock
      pll_run     <= running;
      core_clk_en <= running;
      ic_clk_en   <= (state_next != ST_RESET);
      // Pin released as input while in reset so the strap can be read
      strap_oe    <= (state_next != ST_RESET);
      strap_out   <= strobe_drive;
      wake_irq    <= (state_next == ST_WAKE) ? (state_reg == ST_PDOWN ? wake_hit
                                                                      : wake_hit_reg)
                                             : '0;
      // return resumes after the power-down instruction
      resume_next <= (state_reg == ST_WAKE) && (state_next == ST_RUN);
    end
  end
  assign download_mode = dl_reg;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_supply_low_reset: assert property (@(posedge clk) disable iff (!rst_b)
    !supply_good_reg |=> core_reset)
    else $error("core left reset with supply low");

  a_por_delay: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(por_done) |-> $past(por_cnt_reg) == CW'(POR_CYCLES - 1))
    else $error("release delay count wrong");

  a_fall_hold: assert property (@(posedge clk) disable iff (!rst_b)
    !rise_ok && fall_ok |-> ##2 core_reset)
    else $error("reset not held while supply falls");

  a_timer_wake: assert property (@(posedge clk) disable iff (!rst_b)
    state_reg == ST_PDOWN && interval_counter_irq && !hold_rst |=> wake_irq.timer)
    else $error("interval counter did not wake");

  a_serial_gate: assert property (@(posedge clk) disable iff (!rst_b)
    state_reg == ST_PDOWN && !power_control_reg.serial_wake_enable
      && !interval_counter_irq && !wake_hit.ext |=> state_reg != ST_WAKE)
    else $error("serial woke without enable");

  a_ext_gate: assert property (@(posedge clk) disable iff (!rst_b)
    state_reg == ST_PDOWN && !power_control_reg.ext_irq_wake_enable
      && !interval_counter_irq && !wake_hit.serial |=> state_reg != ST_WAKE)
    else $error("external line woke without enable");

  a_resume: assert property (@(posedge clk) disable iff (!rst_b)
    state_reg == ST_WAKE && interrupt_return && !hold_rst |=> resume_next && !core_reset)
    else $error("no resume after interrupt return");

  a_pin_reset: assert property (@(posedge clk) disable iff (!rst_b)
    pin_rst |=> core_reset && !download_mode ##1 core_reset)
    else $error("reset pin did not reset");

  a_strap_mode: assert property (@(posedge clk) disable iff (!rst_b)
    release_now |=> download_mode == !$past(strap_lvl))
    else $error("mode not taken from strap");

  a_strap_input: assert property (@(posedge clk) disable iff (!rst_b)
    core_reset |-> !strap_oe)
    else $error("strobe pin driven in reset");

  a_pd_clocks: assert property (@(posedge clk) disable iff (!rst_b)
    state_reg == ST_PDOWN |-> !pll_run && !core_clk_en && ic_clk_en)
    else $error("clocks wrong in power-down");

  a_cycle_start: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(core_reset) |-> $past(por_done))
    else $error("reset released before delay");

  // ----------------------------------------
  // Wake walk and boot sequences
  // ----------------------------------------
  // Core asks to sleep while running
  sequence s_pd_entry;
    state_reg == ST_RUN && pd_request && !hold_rst;
  endsequence

  // An enabled source fires while asleep
  sequence s_sleep_woken;
    state_reg == ST_PDOWN && any_wake && !hold_rst;
  endsequence

  // Handler finishes with its interrupt return
  sequence s_handler_done;
    state_reg == ST_WAKE && interrupt_return && !hold_rst;
  endsequence

  // Handler still running
  sequence s_handler_busy;
    state_reg == ST_WAKE && !interrupt_return && !hold_rst;
  endsequence

  a_pd_entry: assert property (@(posedge clk) disable iff (!rst_b)
    s_pd_entry |=> state_reg == ST_PDOWN && !pll_run && !core_clk_en && ic_clk_en)
    else $error("power-down entry clocks wrong");

  a_wake_clocks: assert property (@(posedge clk) disable iff (!rst_b)
    s_sleep_woken |=> state_reg == ST_WAKE && pll_run && core_clk_en && wake_irq != '0)
    else $error("wake did not restart clocks");

  a_wake_held: assert property (@(posedge clk) disable iff (!rst_b)
    s_handler_busy |=> $stable(wake_irq) && state_reg == ST_WAKE)
    else $error("wake source not held during handler");

  a_wake_sequence: assert property (@(posedge clk) disable iff (!rst_b)
    s_sleep_woken ##1 s_handler_done |=> resume_next && pll_run && wake_irq == '0)
    else $error("wake and return walk broken");

  a_resume_pulse: assert property (@(posedge clk) disable iff (!rst_b)
    resume_next |=> !resume_next)
    else $error("resume pulse longer than one cycle");

  a_release_strap: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(core_reset) |-> strap_oe && $past(release_now))
    else $error("strobe pin not driven after release");

  a_reset_quiet: assert property (@(posedge clk) disable iff (!rst_b)
    core_reset |-> !pll_run && !core_clk_en && !ic_clk_en && wake_irq == '0 && !resume_next)
    else $error("outputs not at defaults in reset");

  a_mode_held: assert property (@(posedge clk) disable iff (!rst_b)
    !release_now && !hold_rst |=> $stable(download_mode))
    else $error("boot mode changed outside release");

  a_pin_delay: assert property (@(posedge clk) disable iff (!rst_b)
    pin_rst |=> por_cnt_reg == '0 && state_reg == ST_RESET)
    else $error("reset pin did not restart delay");

  a_no_spurious_wake: assert property (@(posedge clk) disable iff (!rst_b)
    state_reg == ST_PDOWN && !any_wake |=> state_reg != ST_WAKE)
    else $error("woke without an enabled source");

endmodule
`default_nettype wire

//--- design/pwr_wake_pkg.sv
// Package of constants and types for power-down wake and boot control
`default_nettype none
package pwr_wake_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_PERIOD_NS  = 8;
  localparam int unsigned POR_DELAY_MS   = 128;
  localparam int unsigned POR_DELAY_CYC  = POR_DELAY_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned SYNC_STAGES    = 2;
  localparam int unsigned MC_CYC         = 12;

  // ----------------------------------------
  // Supply comparator thresholds in mV
  // ----------------------------------------
  localparam int unsigned POR_RISE_MV    = 2450;
  localparam int unsigned POR_FALL_MV    = 1000;

  // ----------------------------------------
  // Wake source numbers (wake_src_t packs them in reverse order, timer at bit 2)
  // ----------------------------------------
  localparam int unsigned WK_TIMER  = 0;
  localparam int unsigned WK_SERIAL = 1;
  localparam int unsigned WK_EXT    = 2;
  localparam int unsigned WK_NUM    = 3;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [3:0] {
    ST_RESET = 4'h1,
    ST_RUN   = 4'h2,
    ST_PDOWN = 4'h4,
    ST_WAKE  = 4'h8
  } pwr_state_t;

  typedef struct packed {
    logic timer;
    logic serial;
    logic ext;
  } wake_src_t;

  typedef struct packed {
    logic serial_wake_enable;
    logic ext_irq_wake_enable;
  } power_control_t;

endpackage
`default_nettype wire

//--- dv/board_model.sv
// Board side model: strap jumper with pull-up and external interrupt source
`timescale 1ns/1ns
`default_nettype none
module board_model
  import pwr_wake_pkg::*;
(
  // Clock
  input  wire logic clk,
  // Device side
  input  wire logic pd_request,
  input  wire logic strap_out,
  input  wire logic strap_oe,
  output logic      strap_in,
  output logic      ext_irq_line_b,
  // Bench controls
  input  wire logic jumper,
  input  wire logic ext_want
);
  int unsigned quiet_cnt = 0;
  // Device drive wins, else jumper pull-down or pull-up
  assign strap_in = strap_oe ? strap_out : !jumper;
  // Line kept high around power-down entry
  always @(posedge clk) begin
    quiet_cnt <= pd_request ? 2 * MC_CYC : (quiet_cnt > 0 ? quiet_cnt - 1 : 0);
  end
  assign ext_irq_line_b = !(ext_want && quiet_cnt == 0);
endmodule
`default_nettype wire

//--- dv/powerdown_wake_and_boot_control_tb_top.sv
// Testbench for power-down wake, power-on reset and strap sampling
`timescale 1ns/1ns
`default_nettype none
module powerdown_wake_and_boot_control_tb_top;
  import pwr_wake_pkg::*;
  logic           clk, rst_b, sup_rise, sup_fall, pin_b, strobe_drive, pd_request;
  logic           ic_irq, ser_irq, ext_want, jumper, irq_ret, strap_in, strap_out, strap_oe;
  logic           ext_b, core_reset, download_mode, pll_run, core_clk_en, ic_clk_en, resume_next;
  wake_src_t      wake_irq;
  power_control_t pcr;
  int             n_errors = 0, checked = 0, cycles = 0;

  pwr_wake_ctrl #(.POR_CYCLES(20)) uut (.clk(clk), .rst_b(rst_b),
    .supply_above_rise(sup_rise), .supply_above_fall(sup_fall), .reset_pin_b(pin_b),
    .strap_in(strap_in), .strap_out(strap_out), .strap_oe(strap_oe),
    .strobe_drive(strobe_drive), .pd_request(pd_request), .power_control_reg(pcr),
    .interval_counter_irq(ic_irq), .serial_irq(ser_irq), .ext_irq_line_b(ext_b),
    .interrupt_return(irq_ret), .core_reset(core_reset), .download_mode(download_mode),
    .pll_run(pll_run), .core_clk_en(core_clk_en), .ic_clk_en(ic_clk_en),
    .wake_irq(wake_irq), .resume_next(resume_next));
  board_model board (.clk(clk), .pd_request(pd_request), .strap_out(strap_out),
    .strap_oe(strap_oe), .strap_in(strap_in), .ext_irq_line_b(ext_b),
    .jumper(jumper), .ext_want(ext_want));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input logic [2:0] seen, input logic [2:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic wait_release();
    for (int i = 0; i < 40 && core_reset !== 1'b0; i++) @(negedge clk);
  endtask
  task automatic pd_enter();
    @(posedge clk) pd_request <= 1'b1;
    @(posedge clk) pd_request <= 1'b0;
    repeat (3) @(negedge clk);
  endtask
  // Enter power-down, raise src; if not expected to wake, the timer wakes instead
  task automatic pd_try(input wake_src_t src, input logic woke);
    pd_enter();
    check({pll_run, core_clk_en, ic_clk_en}, 3'h1, "clocks in power-down");
    @(posedge clk) begin ic_irq <= src.timer; ser_irq <= src.serial; ext_want <= src.ext; end
    for (int i = 0; i < 40 && pll_run !== 1'b1; i++) @(negedge clk);
    check(pll_run, woke, "wake decision");
    if (!woke) begin
      @(posedge clk) ic_irq <= 1'b1;
      for (int i = 0; i < 10 && pll_run !== 1'b1; i++) @(negedge clk);
      src = wake_src_t'(3'h4);
    end
    check(wake_irq, src, "wake source");
    @(posedge clk) begin ic_irq <= 0; ser_irq <= 0; ext_want <= 0; irq_ret <= 1; end
    @(posedge clk) irq_ret <= 1'b0;
    for (int i = 0; i < 5 && resume_next !== 1'b1; i++) @(negedge clk);
    check(resume_next, 1'b1, "resume pulse missing");
    @(negedge clk) check(resume_next, 1'b0, "resume pulse too long");
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_por();
    repeat (50) @(negedge clk);
    check(core_reset, 1'b1, "reset with supply low");
    @(posedge clk) begin sup_rise <= 1'b1; sup_fall <= 1'b1; end
    repeat (15) @(negedge clk);
    check({core_reset, strap_oe}, 3'h2, "early release or strap driven");
    wait_release();
    check({core_reset, download_mode, pll_run}, 3'h1, "power-up state");
    check({core_clk_en, ic_clk_en, strap_oe}, 3'h7, "clocks after release");
    @(posedge clk) strobe_drive <= 1'b0;
    repeat (3) @(negedge clk);
    check({strap_oe, strap_out, strap_in}, 3'h4, "strobe as output");
    @(posedge clk) strobe_drive <= 1'b1;
    $display("test por done");
  endtask
  task automatic t_fall();
    @(posedge clk) sup_rise <= 1'b0;
    repeat (10) @(negedge clk);
    check(core_reset, 1'b1, "no reset between thresholds");
    @(posedge clk) sup_fall <= 1'b0;
    repeat (6) @(negedge clk);
    check(core_reset, 1'b1, "no reset below low threshold");
    @(posedge clk) begin sup_rise <= 1'b1; sup_fall <= 1'b1; end
    wait_release();
    check(core_reset, 1'b0, "no release after supply return");
    $display("test supply fall done");
  endtask
  task automatic t_wakes();
    @(posedge clk) pcr <= power_control_t'(2'h0);
    pd_try(wake_src_t'(3'h4), 1'b1); // timer
    pd_try(wake_src_t'(3'h2), 1'b0); // serial, disabled
    @(posedge clk) pcr <= power_control_t'(2'h2);
    pd_try(wake_src_t'(3'h2), 1'b1);
    pd_try(wake_src_t'(3'h1), 1'b0); // external, disabled
    @(posedge clk) pcr <= power_control_t'(2'h1);
    pd_try(wake_src_t'(3'h1), 1'b1);
    $display("test wakes done");
  endtask
  task automatic t_pinreset();
    pd_enter();
    @(posedge clk) begin jumper <= 1'b1; pin_b <= 1'b0; end
    repeat (6) @(negedge clk);
    check(core_reset, 1'b1, "pin reset in power-down");
    @(posedge clk) pin_b <= 1'b1;
    wait_release();
    check({core_reset, download_mode, pll_run}, 3'h3, "state after pin reset");
    check(wake_irq, 3'h0, "wake flags after pin reset");
    $display("test pin reset done");
  endtask

  // ----------------------------------------
  // Clock, timeout and main sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      n_errors++;
      give_verdict();
    end
  end
  initial begin
    rst_b = 0; sup_rise = 0; sup_fall = 0; pin_b = 1; strobe_drive = 1; pd_request = 0;
    ic_irq = 0; ser_irq = 0; ext_want = 0; jumper = 0; irq_ret = 0; pcr = '0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    t_por();
    t_fall();
    t_wakes();
    t_pinreset();
    give_verdict();
  end
endmodule
`default_nettype wire
